// ### rcc_defs.svh
`ifndef RCC_DEFS_SVH
`define RCC_DEFS_SVH

// register indices; byte address is four times the index
`define RCC_IDX_BORCTL 12'h811
`define RCC_IDX_CAUSE0 12'h813
`define RCC_IDX_CAUSE1 12'h814
`define RCC_IDX_CFG 12'h816
`define RCC_IDX_STAT 12'h817
`define RCC_IDX_W 12

// cause register 0 after power-on, unknown brown-out bit taken as 1
`define RCC_CAUSE0_POR 8'h3d
`define RCC_CAUSE1_POR 1'b1
`define RCC_SOFTWARE_BROWNOUT_ENABLE_POR 1'b1

// brown-out mode encodings
`define RCC_BORMODE_ON 2'b11
`define RCC_BORMODE_NOSLEEP 2'b10
`define RCC_BORMODE_SW 2'b01

// power-up timer select value that disables the timer
`define RCC_POWERUP_TIMER_OFF 2'b11

// timing
`define RCC_POWERUP_TIMER_MS 64
`define RCC_CLK_KHZ 250000
`define RCC_START_DLY 10
`define RCC_FILT_CYC 4

`define RCC_IRQ_VECTOR 16'h0004

// default configuration word image (erased part: low-power detector off)
`define RCC_CFG_DEFAULT 10'h0cb

`endif

// ### rcc_pkg.sv
package rcc_pkg;

  typedef struct packed {
    logic sw_pullup;
    logic saf_enable;
    logic [1:0] powerup_timer_select;
    logic stack_reset_enable_cfg;
    logic low_voltage_program_cfg;
    logic external_reset_enable_cfg;
    logic low_power_brownout_enable_cfg;
    logic [1:0] brownout_mode_cfg;
  } rcc_cfg_s;

  typedef struct packed {
    logic stack_over_flag;
    logic stack_under_flag;
    logic window_violation_flag;
    logic watchdog_reset_flag;
    logic external_reset_flag;
    logic reset_instr_flag;
    logic por_flag;
    logic brownout_flag;
  } rcc_cause0_s;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } rcc_stat_s;

  typedef enum logic [5:0] {
    RCC_ST_HOLD = 6'h01,
    RCC_ST_POWERUP_TIMER = 6'h02,
    RCC_ST_OST = 6'h04,
    RCC_ST_PIN = 6'h08,
    RCC_ST_DLY = 6'h10,
    RCC_ST_RUN = 6'h20
  } rcc_state_e;

endpackage

// ### rcc_reset_ctrl.sv
`timescale 1ns/1ns
`include "rcc_defs.svh"

module rcc_reset_ctrl #(
  parameter int POWERUP_TIMER_CYCLES = `RCC_POWERUP_TIMER_MS * `RCC_CLK_KHZ,
  parameter int FILT_CYCLES = `RCC_FILT_CYC,
  parameter int PC_W = 15,
  parameter logic [PC_W-1:0] FLASH_END = 15'h3fff,
  parameter logic [PC_W-1:0] SAF_BASE = 15'h3f80,
  parameter logic [9:0] CFG_DEFAULT = `RCC_CFG_DEFAULT
) (
  input wire logic clk, // 250 MHz system clock
  input wire logic reset_n, // power-on reset, async
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [13:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic brownout_det, // main detector sees undervoltage
  input wire logic low_power_brownout_detector, // low-power detector trips
  input wire logic brownout_ready_status, // main detector armed
  input wire logic sleep_state, // core is asleep
  input wire logic sleep_enter, // sleep instruction pulse
  input wire logic watchdog_clear_instr, // watchdog clear pulse
  input wire logic watchdog_timeout, // watchdog time-out pulse
  input wire logic watchdog_window_viol, // window violation pulse
  input wire logic reset_instr, // reset instruction pulse
  input wire logic stack_over, // stack overflow pulse
  input wire logic stack_under, // stack underflow pulse
  input wire logic exec_strobe, // instruction really executed
  input wire logic [PC_W-1:0] exec_addr, // address of executed word
  input wire logic prog_mode_exit, // leaving programming mode
  input wire logic osc_ready, // oscillator start-up timer done
  input wire logic ost_required, // oscillator needs start-up timer
  input wire logic wake_irq, // interrupt wake from sleep pulse
  input wire logic wake_wdt, // watchdog wake from sleep pulse
  input wire logic global_irq_enable, // core interrupt enable
  input wire logic external_reset_pin_in, // external reset pin level
  output logic external_reset_pin_out, // pin output value
  output logic external_reset_pin_oe_n, // pin output enable, low drives
  output logic external_reset_pin_pullup, // weak pull-up enable
  output logic main_brownout_enable, // main detector power
  output logic brownout_to_power, // combined brown-out to power control
  output logic por_rearm, // re-arm power-on detector
  output logic irq_suppress, // ignore concurrent interrupt requests
  output logic core_reset_n, // core reset, low holds core
  output logic wake_resume, // resume at pc+1
  output logic vector_load, // load interrupt vector after resume
  output logic [15:0] vector_addr // interrupt vector address
);

  localparam int FILT_W = $clog2(FILT_CYCLES + 1);
  localparam int POWERUP_TIMER_W = $clog2(POWERUP_TIMER_CYCLES + 1);
  localparam int DLY_W = 4;

  rcc_pkg::rcc_state_e state;
  rcc_pkg::rcc_state_e next_state;
  rcc_pkg::rcc_cfg_s cfg;
  rcc_pkg::rcc_cfg_s next_cfg;
  rcc_pkg::rcc_cause0_s cause0;
  rcc_pkg::rcc_cause0_s next_cause0;
  rcc_pkg::rcc_stat_s stat;
  rcc_pkg::rcc_stat_s next_stat;
  logic mem_violation_flag;
  logic next_mem_violation_flag;
  logic software_brownout_enable;
  logic next_software_brownout_enable;
  logic por_path;
  logic next_por_path;
  logic pin_low_f;
  logic [FILT_W-1:0] filt_cnt;
  logic [POWERUP_TIMER_W-1:0] powerup_timer_cnt;
  logic [DLY_W-1:0] dly_cnt;
  logic hold_q_n;

  // register decode
  wire [`RCC_IDX_W-1:0] reg_idx = paddr[13:2];
  wire sel_borctl = reg_idx == `RCC_IDX_BORCTL;
  wire sel_cause0 = reg_idx == `RCC_IDX_CAUSE0;
  wire sel_cause1 = reg_idx == `RCC_IDX_CAUSE1;
  wire sel_cfg = reg_idx == `RCC_IDX_CFG;
  wire sel_stat = reg_idx == `RCC_IDX_STAT;
  wire mapped = sel_borctl | sel_cause0 | sel_cause1 | sel_cfg | sel_stat;
  wire wr_access = psel & penable & pwrite & mapped;
  wire wr_borctl = wr_access & sel_borctl;
  wire wr_cause0 = wr_access & sel_cause0;
  wire wr_cause1 = wr_access & sel_cause1;
  wire wr_cfg = wr_access & sel_cfg;
  wire wr_stat = wr_access & sel_stat;

  // brown-out path
  wire mode_on = cfg.brownout_mode_cfg == `RCC_BORMODE_ON;
  wire mode_nosleep = cfg.brownout_mode_cfg == `RCC_BORMODE_NOSLEEP;
  wire mode_sw = cfg.brownout_mode_cfg == `RCC_BORMODE_SW;
  wire main_en = mode_on | (mode_nosleep & ~sleep_state)
    | (mode_sw & software_brownout_enable);
  wire main_bor = brownout_det & main_en;
  wire lp_bor = low_power_brownout_detector & cfg.low_power_brownout_enable_cfg;
  wire bor_any = main_bor | lp_bor;

  // external reset pin
  wire ext_enabled = cfg.low_voltage_program_cfg | cfg.external_reset_enable_cfg;
  wire ext_active = ext_enabled & pin_low_f;

  // execution area check only on executed words, never on prefetch
  wire bad_area = (exec_addr > FLASH_END)
    | (cfg.saf_enable & (exec_addr >= SAF_BASE));
  wire in_run = state == rcc_pkg::RCC_ST_RUN;
  wire mem_violation_flag_evt = in_run & exec_strobe & bad_area;

  wire wdt_evt = in_run & (watchdog_timeout | watchdog_window_viol);
  wire wv_evt = in_run & watchdog_window_viol;
  wire ri_evt = in_run & reset_instr;
  wire ovf_evt = in_run & stack_over & cfg.stack_reset_enable_cfg;
  wire unf_evt = in_run & stack_under & cfg.stack_reset_enable_cfg;
  wire external_reset_pin_evt = in_run & ext_active;

  // any request pulls the core reset low in the same cycle
  wire req_now = bor_any | ext_active | wdt_evt | ri_evt | ovf_evt | unf_evt
    | mem_violation_flag_evt | prog_mode_exit;
  wire powerup_timer_on = cfg.powerup_timer_select != `RCC_POWERUP_TIMER_OFF;

  assign core_reset_n = hold_q_n & ~req_now;
  assign irq_suppress = mem_violation_flag_evt;
  assign main_brownout_enable = main_en;
  assign brownout_to_power = bor_any;
  assign por_rearm = mode_nosleep & lp_bor;

  // the pin is only ever an input; nothing internal may pull it low
  assign external_reset_pin_out = 1'b0;
  assign external_reset_pin_oe_n = 1'b1;
  assign external_reset_pin_pullup = ext_enabled | cfg.sw_pullup;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign vector_addr = `RCC_IRQ_VECTOR;

  // glitch filter: the level must stand for FILT_CYCLES before it counts
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      filt_cnt <= '0;
      pin_low_f <= 1'b0;
    end
    else if (~external_reset_pin_in == pin_low_f)
      filt_cnt <= '0;
    else if (filt_cnt == FILT_W'(FILT_CYCLES - 1))
    begin
      filt_cnt <= '0;
      pin_low_f <= ~external_reset_pin_in;
    end
    else
      filt_cnt <= filt_cnt + FILT_W'(1);
  end

  // start-up sequencer
  always_comb
  begin
    next_state = state;
    next_por_path = por_path;
    if (bor_any | prog_mode_exit)
      next_por_path = 1'b1;
    case (state)
      rcc_pkg::RCC_ST_HOLD:
        if (!bor_any && !prog_mode_exit)
        begin
          if (por_path && powerup_timer_on)
            next_state = rcc_pkg::RCC_ST_POWERUP_TIMER;
          else if (por_path)
            next_state = rcc_pkg::RCC_ST_OST;
          else
            next_state = rcc_pkg::RCC_ST_PIN;
        end
      rcc_pkg::RCC_ST_POWERUP_TIMER:
        if (powerup_timer_cnt == POWERUP_TIMER_W'(POWERUP_TIMER_CYCLES - 1))
          next_state = rcc_pkg::RCC_ST_OST;
      rcc_pkg::RCC_ST_OST:
        if (osc_ready || !ost_required)
          next_state = rcc_pkg::RCC_ST_PIN;
      rcc_pkg::RCC_ST_PIN:
        if (!ext_active)
          next_state = rcc_pkg::RCC_ST_DLY;
      rcc_pkg::RCC_ST_DLY:
        if (dly_cnt == DLY_W'(`RCC_START_DLY - 1))
        begin
          next_state = rcc_pkg::RCC_ST_RUN;
          next_por_path = 1'b0;
        end
      rcc_pkg::RCC_ST_RUN:
        next_state = rcc_pkg::RCC_ST_RUN;
      default:
        next_state = rcc_pkg::RCC_ST_HOLD;
    endcase
    // timers do not look at the pin; only a new request restarts the chain
    if (bor_any || prog_mode_exit || (req_now && in_run))
      next_state = rcc_pkg::RCC_ST_HOLD;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= rcc_pkg::RCC_ST_HOLD;
      por_path <= 1'b1;
    end
    else
    begin
      state <= next_state;
      por_path <= next_por_path;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      powerup_timer_cnt <= '0;
    else if (state == rcc_pkg::RCC_ST_POWERUP_TIMER && next_state == rcc_pkg::RCC_ST_POWERUP_TIMER)
      powerup_timer_cnt <= powerup_timer_cnt + POWERUP_TIMER_W'(1);
    else
      powerup_timer_cnt <= '0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dly_cnt <= '0;
    else if (state == rcc_pkg::RCC_ST_DLY && next_state == rcc_pkg::RCC_ST_DLY)
      dly_cnt <= dly_cnt + DLY_W'(1);
    else
      dly_cnt <= '0;
  end

  // released only on a clock edge, asserted at once through req_now
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hold_q_n <= 1'b0;
    else
      hold_q_n <= next_state == rcc_pkg::RCC_ST_RUN;
  end

  // cause flags: software write first, hardware events override it
  always_comb
  begin
    next_cause0 = cause0;
    next_mem_violation_flag = mem_violation_flag;
    next_stat = stat;
    next_software_brownout_enable = software_brownout_enable;
    next_cfg = cfg;
    if (wr_cause0)
      next_cause0 = pwdata[7:0];
    if (wr_cause1)
      next_mem_violation_flag = pwdata[1];
    if (wr_stat)
      next_stat = pwdata[1:0];
    if (wr_borctl)
      next_software_brownout_enable = pwdata[7];
    if (wr_cfg)
      next_cfg = pwdata[9:0];
    if (sleep_enter)
    begin
      next_stat.timeout_flag = 1'b1;
      next_stat.powerdown_flag = 1'b0;
    end
    if (watchdog_clear_instr)
      next_stat = 2'b11;
    if (wake_wdt)
      next_stat = 2'b00;
    if (wake_irq)
    begin
      next_stat.timeout_flag = 1'b1;
      next_stat.powerdown_flag = 1'b0;
    end
    if (external_reset_pin_evt)
    begin
      next_cause0.external_reset_flag = 1'b0;
      if (sleep_state)
        next_stat = 2'b10;
    end
    if (wdt_evt)
    begin
      next_cause0.watchdog_reset_flag = 1'b0;
      next_stat.timeout_flag = 1'b0;
    end
    if (wv_evt)
      next_cause0.window_violation_flag = 1'b0;
    if (ri_evt)
      next_cause0.reset_instr_flag = 1'b0;
    if (ovf_evt)
      next_cause0.stack_over_flag = 1'b1;
    if (unf_evt)
      next_cause0.stack_under_flag = 1'b1;
    if (mem_violation_flag_evt)
      next_mem_violation_flag = 1'b0;
    if (bor_any)
    begin
      next_cause0 = {6'h0f, cause0.por_flag, 1'b0};
      next_stat = 2'b11;
      next_software_brownout_enable = `RCC_SOFTWARE_BROWNOUT_ENABLE_POR;
    end
    if (prog_mode_exit)
    begin
      next_cause0 = `RCC_CAUSE0_POR;
      next_mem_violation_flag = `RCC_CAUSE1_POR;
      next_stat = 2'b11;
      next_software_brownout_enable = `RCC_SOFTWARE_BROWNOUT_ENABLE_POR;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cause0 <= `RCC_CAUSE0_POR;
      mem_violation_flag <= `RCC_CAUSE1_POR;
      stat <= 2'b11;
      software_brownout_enable <= `RCC_SOFTWARE_BROWNOUT_ENABLE_POR;
      cfg <= CFG_DEFAULT;
    end
    else
    begin
      cause0 <= next_cause0;
      mem_violation_flag <= next_mem_violation_flag;
      stat <= next_stat;
      software_brownout_enable <= next_software_brownout_enable;
      cfg <= next_cfg;
    end
  end

  // read data captured in the setup cycle so the access completes at once
  wire [31:0] rd_mux =
    sel_borctl ? {24'h0, software_brownout_enable, 6'h00, brownout_ready_status} :
    sel_cause0 ? {24'h0, cause0} :
    sel_cause1 ? {30'h0, mem_violation_flag, 1'b0} :
    sel_cfg ? {22'h0, cfg} :
    sel_stat ? {18'h0, state, 6'h00, stat} : 32'h0;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= rd_mux;
  end

  // interrupt wake from sleep: resume, then vector if interrupts are enabled
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wake_resume <= 1'b0;
      vector_load <= 1'b0;
    end
    else
    begin
      wake_resume <= wake_irq & sleep_state;
      vector_load <= wake_resume & global_irq_enable;
    end
  end

endmodule // rcc_reset_ctrl

// ### rcc_pin_model.sv
`timescale 1ns/1ns
// far side of the external reset pin: a supervisor that can pull it low
module rcc_pin_model (
  input wire logic clk, // system clock
  input wire logic hold_low, // supervisor pulls the pin low
  input wire logic pull_en, // weak pull-up enabled by the device
  input wire logic dut_oe_n, // device output enable, low drives
  input wire logic dut_out, // device output value
  output logic pin // resolved pin level
);
  logic toggle = 1'b0;
  // a floating pin must not settle to a lucky constant
  always @(posedge clk)
    toggle <= ~toggle;
  assign pin = !dut_oe_n ? dut_out : hold_low ? 1'b0 : pull_en ? 1'b1 : toggle;
endmodule // rcc_pin_model

// ### rcc_reset_checker.sv
`timescale 1ns/1ns
module rcc_reset_checker #(
  parameter int PC_W = 15,
  parameter logic [PC_W-1:0] FLASH_END = 15'h3fff
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // power-on reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic reset_instr, // reset instruction
  input wire logic brownout_to_power, // combined brown-out
  input wire logic core_reset_n, // core reset
  input wire logic por_rearm, // power-on re-arm
  input wire logic low_power_brownout_detector, // low-power trip
  input wire logic exec_strobe, // executed instruction
  input wire logic [PC_W-1:0] exec_addr, // executed address
  input wire logic irq_suppress, // interrupts ignored
  input wire logic wake_resume, // resume pulse
  input wire logic vector_load, // vector pulse
  input wire logic [15:0] vector_addr, // vector address
  input wire logic external_reset_pin_oe_n // pin enable
);
  logic [7:0] low_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      low_cnt <= 8'h00;
    else if (core_reset_n)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;
  end
  pin_never_driven_a: assert property (external_reset_pin_oe_n)
    else $error("reset pin driven");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("access not ready");
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  instr_holds_a: assert property (reset_instr |-> !core_reset_n)
    else $error("reset instruction ignored");
  bor_holds_a: assert property (brownout_to_power |-> !core_reset_n)
    else $error("brown-out not holding core");
  rearm_lp_a: assert property (por_rearm |-> low_power_brownout_detector && brownout_to_power)
    else $error("re-arm without low-power trip");
  release_delay_a: assert property ($rose(core_reset_n) |-> low_cnt >= 8'd10)
    else $error("core released too soon");
  mem_violation_flag_reset_a: assert property (exec_strobe && exec_addr > FLASH_END |-> irq_suppress && !core_reset_n)
    else $error("violation not taken");
  no_prefetch_a: assert property (irq_suppress |-> exec_strobe)
    else $error("violation without execution");
  vector_after_a: assert property (vector_load |-> $past(wake_resume) && vector_addr == 16'h0004)
    else $error("vector out of order");
  cover property ($rose(core_reset_n));
  cover property (irq_suppress);
  cover property (vector_load);
endmodule // rcc_reset_checker
bind rcc_reset_ctrl rcc_reset_checker #(.PC_W(PC_W), .FLASH_END(FLASH_END)) u_chk (.*);

// ### tb_top.sv
`timescale 1ns/1ns
`include "rcc_defs.svh"
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, hold_low = 1'b1;
  logic [11:0] ev = 12'h000;
  logic brownout_ready_status = 1'b1, sleep_state = 1'b0, exec_strobe = 1'b0;
  logic [14:0] exec_addr = 15'h0000;
  logic osc_ready = 1'b0, ost_required = 1'b1, global_irq_enable = 1'b0;
  logic external_reset_pin_in, external_reset_pin_out, external_reset_pin_oe_n;
  logic external_reset_pin_pullup, main_brownout_enable, brownout_to_power, por_rearm;
  logic irq_suppress, core_reset_n, wake_resume, vector_load;
  logic [15:0] vector_addr;
  int failures = 0;
  int samples_checked = 0;
  wire reset_instr = ev[0];
  wire watchdog_timeout = ev[1];
  wire watchdog_window_viol = ev[2];
  wire stack_over = ev[3];
  wire stack_under = ev[4];
  wire prog_mode_exit = ev[5];
  wire wake_irq = ev[6];
  wire sleep_enter = ev[7];
  wire watchdog_clear_instr = ev[8];
  wire wake_wdt = ev[9];
  wire brownout_det = ev[10];
  wire low_power_brownout_detector = ev[11];
  // short power-up count keeps the run brief
  rcc_reset_ctrl #(.POWERUP_TIMER_CYCLES(20)) u_dut (.*);
  rcc_pin_model u_pin (.clk(clk), .hold_low(hold_low), .pull_en(external_reset_pin_pullup),
    .dut_oe_n(external_reset_pin_oe_n), .dut_out(external_reset_pin_out),
    .pin(external_reset_pin_in));
  always #2 clk = ~clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      final_report();
    end
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, wd, rd, err);
  endtask
  task automatic rd_chk(input string name, input logic [11:0] idx, input logic [31:0] mask,
    input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0, rd, err);
    check(name, rd & mask, exp);
  endtask
  task automatic wait_run(output int n);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 300)
    begin
      failures++;
      final_report();
    end
  endtask
  task automatic pulse(input int b, output logic core);
    @(posedge clk);
    ev[b] <= 1'b1;
    #1 core = core_reset_n;
    @(posedge clk);
    ev <= 12'h000;
  endtask
  task automatic event_reset(input int b, input logic [31:0] exp0);
    logic core;
    int n;
    pulse(b, core);
    check("core held", core, 1'b0);
    wait_run(n);
    rd_chk("cause0", `RCC_IDX_CAUSE0, 32'hff, exp0);
  endtask
  task automatic pin_low(input int cyc, input logic [31:0] exp_core);
    @(posedge clk);
    hold_low <= 1'b1;
    repeat (cyc) @(posedge clk);
    hold_low <= 1'b0;
    #1 check("core after pin", core_reset_n, exp_core);
  endtask
  task automatic exec(input logic [14:0] a, input logic s, input logic [31:0] exp_core);
    @(posedge clk);
    exec_strobe <= s;
    exec_addr <= a;
    #1 check("core on exec", core_reset_n, exp_core);
    @(posedge clk);
    exec_strobe <= 1'b0;
  endtask
  task automatic t_startup();
    int n;
    repeat (20) @(posedge clk);
    check("core pin low", core_reset_n, 1'b0);
    hold_low <= 1'b0;
    repeat (20) @(posedge clk);
    check("core osc wait", core_reset_n, 1'b0);
    osc_ready <= 1'b1;
    wait_run(n);
    check("start delay", (n >= 10 && n <= 20), 1'b1);
    $display("test startup done");
  endtask
  task automatic t_regs();
    logic [31:0] rd;
    logic err;
    rd_chk("cause0", `RCC_IDX_CAUSE0, 32'hffffffff, 32'h3d);
    rd_chk("cause1", `RCC_IDX_CAUSE1, 32'hffffffff, 32'h2);
    rd_chk("borctl", `RCC_IDX_BORCTL, 32'hffffffff, 32'h81);
    rd_chk("cfg", `RCC_IDX_CFG, 32'hffffffff, 32'h0cb);
    rd_chk("stat", `RCC_IDX_STAT, 32'h3f03, 32'h2003);
    apb(1'b0, 12'h812, 32'h0, rd, err);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_pin();
    int n;
    pin_low(2, 1'b1);
    repeat (8) @(posedge clk);
    check("core glitch", core_reset_n, 1'b1);
    pin_low(8, 1'b0);
    wait_run(n);
    check("pin delay", (n >= 10 && n <= 20), 1'b1);
    rd_chk("cause0", `RCC_IDX_CAUSE0, 32'hff, 32'h35);
    $display("test pin done");
  endtask
  task automatic t_events();
    logic core;
    event_reset(0, 32'h31);
    event_reset(1, 32'h21);
    rd_chk("stat", `RCC_IDX_STAT, 32'h3, 32'h1);
    event_reset(2, 32'h01);
    wr(`RCC_IDX_CFG, 32'h0eb);
    event_reset(3, 32'h81);
    wr(`RCC_IDX_CFG, 32'h0cb);
    pulse(4, core);
    check("stack off", core, 1'b1);
    rd_chk("cause0", `RCC_IDX_CAUSE0, 32'hff, 32'h81);
    $display("test events done");
  endtask
  task automatic t_mem_violation_flag();
    int n;
    wr(`RCC_IDX_CFG, 32'h1ab);
    exec(15'h3f7f, 1'b1, 1'b1);
    exec(15'h7fff, 1'b0, 1'b1);
    exec(15'h3f80, 1'b1, 1'b0);
    wait_run(n);
    rd_chk("cause1", `RCC_IDX_CAUSE1, 32'h2, 32'h0);
    wr(`RCC_IDX_CAUSE1, 32'h2);
    rd_chk("cause1", `RCC_IDX_CAUSE1, 32'h2, 32'h2);
    exec(15'h4000, 1'b1, 1'b0);
    wait_run(n);
    wr(`RCC_IDX_CAUSE1, 32'h2);
    $display("test mem_violation_flag done");
  endtask
  task automatic t_bor();
    int n;
    wr(`RCC_IDX_CFG, 32'h0cb);
    @(posedge clk);
    ev[10] <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("bor power", brownout_to_power, 1'b1);
    @(posedge clk);
    ev[10] <= 1'b0;
    wait_run(n);
    rd_chk("cause0", `RCC_IDX_CAUSE0, 32'hff, 32'h3c);
    rd_chk("cause1", `RCC_IDX_CAUSE1, 32'h2, 32'h2);
    wr(`RCC_IDX_CFG, 32'h0ae);
    wr(`RCC_IDX_CAUSE0, 32'hff);
    @(posedge clk);
    ev[11] <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check("rearm", por_rearm, 1'b1);
    check("lp power", brownout_to_power, 1'b1);
    @(posedge clk);
    ev[11] <= 1'b0;
    wait_run(n);
    check("powerup_timer length", n >= 30, 1'b1);
    rd_chk("cause0", `RCC_IDX_CAUSE0, 32'hff, 32'h3e);
    $display("test bor done");
  endtask
  task automatic t_pin_cfg();
    int n;
    wr(`RCC_IDX_CFG, 32'h0c3);
    #1 check("pullup off", external_reset_pin_pullup, 1'b0);
    pin_low(8, 1'b1);
    wr(`RCC_IDX_CFG, 32'h2c3);
    #1 check("pullup sw", external_reset_pin_pullup, 1'b1);
    wr(`RCC_IDX_CFG, 32'h0d3);
    pin_low(8, 1'b0);
    wait_run(n);
    wr(`RCC_IDX_CFG, 32'h0c1);
    wr(`RCC_IDX_BORCTL, 32'h00);
    #1 check("sw bor off", main_brownout_enable, 1'b0);
    wr(`RCC_IDX_BORCTL, 32'h80);
    #1 check("sw bor on", main_brownout_enable, 1'b1);
    wr(`RCC_IDX_CFG, 32'h0cb);
    $display("test pin cfg done");
  endtask
  task automatic t_wake();
    logic core;
    int n;
    pulse(8, core);
    pulse(7, core);
    sleep_state <= 1'b1;
    global_irq_enable <= 1'b1;
    pulse(6, core);
    sleep_state <= 1'b0;
    n = 0;
    while (wake_resume !== 1'b1 && n < 5)
    begin
      @(posedge clk);
      n++;
    end
    check("resume", wake_resume, 1'b1);
    @(posedge clk);
    check("vector", vector_load, 1'b1);
    check("vector addr", vector_addr, 32'h0004);
    pulse(9, core);
    $display("test wake done");
  endtask
  task automatic t_prog();
    event_reset(5, 32'h3d);
    rd_chk("cause1", `RCC_IDX_CAUSE1, 32'h2, 32'h2);
    rd_chk("stat", `RCC_IDX_STAT, 32'h3, 32'h3);
    $display("test prog done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_startup();
    t_regs();
    t_pin();
    t_events();
    t_mem_violation_flag();
    t_bor();
    t_pin_cfg();
    t_wake();
    t_prog();
    final_report();
  end
endmodule // tb_top
